// ---- logic/nfc_pkg.sv ----
`default_nettype none
package nfc_pkg;
	// command codes driven onto the shared port
	localparam logic [7:0] CMD_READ_A      = 8'h00;
	localparam logic [7:0] CMD_READ_B      = 8'h01;
	localparam logic [7:0] CMD_READ_SPARE  = 8'h50;
	localparam logic [7:0] CMD_SERIAL_IN   = 8'h80;
	localparam logic [7:0] CMD_PROG_EXEC   = 8'h10;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_CONF  = 8'hD0;
	localparam logic [7:0] CMD_STATUS      = 8'h70;
	localparam logic [7:0] CMD_RESET       = 8'hFF;
	// status byte fields
	localparam int STAT_FAIL_BIT  = 0;
	localparam int STAT_READY_BIT = 6;
	localparam int STAT_WPOFF_BIT = 7;
	// page geometry
	localparam int PAGE_BYTES  = 528;
	localparam int MAIN_BYTES  = 512;
	localparam int BLOCK_PAGES = 32;
	localparam int MAX_PROGS   = 3;
	// host register map (word offsets on the local port)
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_ADDR   = 4'h1;
	localparam logic [3:0] REG_WDATA  = 4'h2;
	localparam logic [3:0] REG_RDATA  = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	// op codes written into REG_CTRL[3:0]
	typedef enum logic [3:0] {
		NFC_OP_READ   = 4'h1,
		NFC_OP_PROG   = 4'h2,
		NFC_OP_ERASE  = 4'h3,
		NFC_OP_STATUS = 4'h4,
		NFC_OP_RESET  = 4'h5,
		NFC_OP_RBYTE  = 4'h6,
		NFC_OP_WBYTE  = 4'h7,
		NFC_OP_EXEC   = 4'h8
	} nfc_op_t;
	localparam int CTRL_READREG_LSB = 4;
	localparam int CTRL_WP_BIT      = 8;
	// pin timing in ns, and cycles at 250 MHz
	localparam int CLK_NS       = 4;
	localparam int STROBE_NS    = 35;
	localparam int CEH_NS       = 100;
	localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int CEH_CYC      = (CEH_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W        = 8;
endpackage : nfc_pkg
`default_nettype wire

// ---- logic/nfc_pin_sync.sv ----
`default_nettype none
// two-stage synchroniser for asynchronous pins
module nfc_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinOut
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			meta_reg <= '0;
			pinOut   <= '0;
		end else begin
			meta_reg <= pinIn;
			pinOut   <= meta_reg;
		end
	end
endmodule : nfc_pin_sync
`default_nettype wire

// ---- logic/nfc_host.sv ----
`default_nettype none
module nfc_host
	import nfc_pkg::*;
#(
	parameter int BUSY_TIMEOUT = 3_000_000
) (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [31:0] regRdData,
	output logic             cmdLatch,
	output logic             addrLatch,
	output logic             chipSel_n,
	output logic             writeStrobe_n,
	output logic             read_strobe_n,
	output logic             writeProt_n,
	output logic      [7:0]  ioOut,
	output logic             ioOe,
	input  wire logic [7:0]  ioIn,
	input  wire logic        ready_busy_n
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_WLOW, ST_WHIGH, ST_RLOW, ST_RHIGH, ST_WAITRDY, ST_CEHIGH
	} nfc_state_t;

	nfc_state_t      state_reg;
	logic [CNT_W-1:0] tmr_reg;
	logic [2:0]      seq_reg;        // step within op
	nfc_op_t         op_reg;
	logic [31:0]     addr_reg;
	logic [7:0]      wdata_reg;
	logic [7:0]      rdata_reg;
	logic [7:0]      rcmd_reg;       // read command byte
	logic            wp_reg;
	logic            timeout_reg;
	logic [21:0]     busyCnt_reg;
	logic [8:0]      syncIn;
	logic [7:0]      ioSync;
	logic            rbSync;
	logic            busy;
	logic [7:0]      curByte;
	logic            curCle;
	logic            curAle;
	logic [2:0]      lastSeq;
	logic [15:0]     progPage_reg;   // page of the last program
	logic [1:0]      progCnt_reg;    // programs of that page since its erase
	logic            cancelProg_reg; // current execute is swapped for a reset byte
	logic            overProg;

	// pins come from another clock domain: sync before use
	nfc_pin_sync #(.W(9)) u_sync (
		.sys_clk (sys_clk),
		.reset   (reset),
		.pinIn   ({ready_busy_n, ioIn}),
		.pinOut  (syncIn)
	);
	assign ioSync = syncIn[7:0];
	assign rbSync = syncIn[8];

	assign busy = (state_reg != ST_IDLE);
	assign writeProt_n = wp_reg;

	// byte and latch pattern for each step of the current op
	always_comb begin
		curByte = wdata_reg;
		curCle  = 1'b0;
		curAle  = 1'b0;
		lastSeq = 3'd0;
		unique case (op_reg)
			NFC_OP_READ: begin
				lastSeq = 3'd3;
				unique case (seq_reg)
					3'd0: begin curByte = rcmd_reg; curCle = 1'b1; end
					3'd1: begin curByte = addr_reg[7:0]; curAle = 1'b1; end
					3'd2: begin curByte = addr_reg[16:9]; curAle = 1'b1; end
					default: begin curByte = addr_reg[24:17]; curAle = 1'b1; end
				endcase
			end
			NFC_OP_PROG: begin // address after 80
				lastSeq = 3'd3;
				unique case (seq_reg)
					3'd0: begin curByte = CMD_SERIAL_IN; curCle = 1'b1; end
					3'd1: begin curByte = addr_reg[7:0]; curAle = 1'b1; end
					3'd2: begin curByte = addr_reg[16:9]; curAle = 1'b1; end
					default: begin curByte = addr_reg[24:17]; curAle = 1'b1; end
				endcase
			end
			NFC_OP_ERASE: begin // block address only
				lastSeq = 3'd3;
				unique case (seq_reg)
					3'd0: begin curByte = CMD_ERASE_SETUP; curCle = 1'b1; end
					3'd1: begin curByte = addr_reg[16:9]; curAle = 1'b1; end
					3'd2: begin curByte = addr_reg[24:17]; curAle = 1'b1; end
					default: begin curByte = CMD_ERASE_CONF; curCle = 1'b1; end
				endcase
			end
			NFC_OP_STATUS: begin curByte = CMD_STATUS; curCle = 1'b1; end
			NFC_OP_RESET:  begin curByte = CMD_RESET; curCle = 1'b1; end
			NFC_OP_EXEC: begin // a cancelled program gets reset, not execute
				curByte = cancelProg_reg ? CMD_RESET : CMD_PROG_EXEC;
				curCle  = 1'b1;
			end
			NFC_OP_WBYTE:  curByte = wdata_reg;
			default: ;
		endcase
	end

	// pin pattern from state
	always_comb begin
		writeStrobe_n = !(state_reg == ST_WLOW);
		read_strobe_n = !(state_reg == ST_RLOW);
		cmdLatch      = (state_reg == ST_WLOW || state_reg == ST_WHIGH) && curCle;
		addrLatch     = (state_reg == ST_WLOW || state_reg == ST_WHIGH) && curAle;
		ioOe          = (state_reg == ST_WLOW || state_reg == ST_WHIGH);
		ioOut         = curByte;
	end

	// chip select: low from op start, only raised by the end-of-read state
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			chipSel_n <= 1'b1;
		else if (state_reg == ST_CEHIGH)
			chipSel_n <= 1'b1;
		else if (regWrite && regAddr == REG_CTRL && !busy && regWrData[3:0] != 4'h0)
			chipSel_n <= 1'b0; // held low through read busy
	end

	// program count of the last page written; past the limit the execute is cancelled.
	// only one page is tracked, so alternating between pages slips past this guard
	assign overProg = (progPage_reg == addr_reg[24:9]) && (progCnt_reg == 2'(MAX_PROGS));

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			progPage_reg   <= 16'h0000;
			progCnt_reg    <= 2'h0;
			cancelProg_reg <= 1'b0;
		end else if (state_reg == ST_IDLE && regWrite && regAddr == REG_CTRL) begin
			cancelProg_reg <= overProg;
			if (regWrData[3:0] == NFC_OP_EXEC && regWrData[CTRL_WP_BIT] && !overProg) begin
				progPage_reg <= addr_reg[24:9];
				progCnt_reg  <= (progPage_reg == addr_reg[24:9]) ? progCnt_reg + 2'h1 : 2'h1;
			end else if (regWrData[3:0] == NFC_OP_ERASE &&
					progPage_reg[15:5] == addr_reg[24:14])
				progCnt_reg <= 2'h0; // erase frees every page of the block
		end
	end

	// software registers
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			addr_reg  <= 32'h0000_0000;
			wdata_reg <= 8'h00;
			rcmd_reg  <= CMD_READ_A;
			wp_reg    <= 1'b0;
		end else if (regWrite) begin
			unique case (regAddr)
				REG_ADDR:  addr_reg  <= regWrData;
				REG_WDATA: wdata_reg <= regWrData[7:0];
				REG_CTRL: begin
					if (!busy) begin
						rcmd_reg <= regWrData[CTRL_READREG_LSB+:2] == 2'd1 ? CMD_READ_B :
							regWrData[CTRL_READREG_LSB+:2] == 2'd2 ? CMD_READ_SPARE : CMD_READ_A;
						wp_reg   <= regWrData[CTRL_WP_BIT];
					end
				end
				default: ;
			endcase
		end
	end

	// strobe sequencer; strobe lengths meet 35 ns pulse widths
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_reg   <= ST_IDLE;
			op_reg      <= NFC_OP_RESET;
			seq_reg     <= 3'd0;
			tmr_reg     <= '0;
			rdata_reg   <= 8'h00;
			timeout_reg <= 1'b0;
			busyCnt_reg <= '0;
		end else begin
			if (tmr_reg != '0)
				tmr_reg <= tmr_reg - 1'b1;
			unique case (state_reg)
				ST_IDLE: begin
					if (regWrite && regAddr == REG_CTRL) begin
						op_reg      <= nfc_op_t'(regWrData[3:0]);
						seq_reg     <= 3'd0;
						tmr_reg     <= CNT_W'(STROBE_CYC);
						timeout_reg <= 1'b0;
						// read byte no command reissued
						state_reg   <= (regWrData[3:0] == NFC_OP_RBYTE) ? ST_RLOW : ST_WLOW;
					end
				end
				ST_WLOW: if (tmr_reg == '0) begin // latched on rise
					state_reg <= ST_WHIGH;
					tmr_reg   <= CNT_W'(STROBE_CYC);
				end
				ST_WHIGH: if (tmr_reg == '0) begin
					if (seq_reg != lastSeq) begin
						seq_reg   <= seq_reg + 3'd1;
						state_reg <= ST_WLOW;
						tmr_reg   <= CNT_W'(STROBE_CYC);
					end else if (op_reg == NFC_OP_READ || op_reg == NFC_OP_ERASE ||
							op_reg == NFC_OP_EXEC || op_reg == NFC_OP_RESET) begin
						state_reg   <= ST_WAITRDY;
						busyCnt_reg <= '0;
						tmr_reg     <= CNT_W'(STROBE_CYC) + CNT_W'(STROBE_CYC);
					end else
						state_reg <= ST_IDLE;
				end
				ST_RLOW: if (tmr_reg == '0) begin // device drives now
					rdata_reg <= ioSync;
					state_reg <= ST_RHIGH;
					tmr_reg   <= CNT_W'(STROBE_CYC);
				end
				ST_RHIGH: if (tmr_reg == '0)
					state_reg <= ST_IDLE;
				ST_WAITRDY: begin // select stays low, device busy
					busyCnt_reg <= busyCnt_reg + 22'd1;
					if (tmr_reg == '0 && rbSync)
						state_reg <= ST_IDLE;
					else if (busyCnt_reg == 22'(BUSY_TIMEOUT)) begin
						timeout_reg <= 1'b1;
						state_reg   <= ST_IDLE;
					end
				end
				ST_CEHIGH: if (tmr_reg == '0)
					state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
			// end a sequential read: select high for 100 ns
			if (state_reg == ST_IDLE && regWrite && regAddr == REG_CTRL
					&& regWrData[3:0] == 4'h0) begin
				state_reg <= ST_CEHIGH;
				tmr_reg   <= CNT_W'(CEH_CYC);
			end
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			regRdData <= 32'h0000_0000;
		else if (regRead) begin
			unique case (regAddr)
				REG_ADDR:   regRdData <= addr_reg;
				REG_RDATA:  regRdData <= {24'h000000, rdata_reg};
				REG_STATUS: regRdData <= {29'h0, timeout_reg, rbSync, busy};
				REG_CTRL:   regRdData <= {23'h0, wp_reg, 8'h00};
				default:    regRdData <= 32'h0000_0000;
			endcase
		end else
			regRdData <= 32'h0000_0000;
	end
endmodule : nfc_host
`default_nettype wire

// ---- bench/nfc_host_assertions.sv ----
`default_nettype none
module nfc_host_assertions (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic        regRead,
	input wire logic [31:0] regRdData,
	input wire logic        cmdLatch,
	input wire logic        addrLatch,
	input wire logic        chipSel_n,
	input wire logic        writeStrobe_n,
	input wire logic        read_strobe_n,
	input wire logic [7:0]  ioOut,
	input wire logic        ioOe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// a write pulse is a run of at least 8 low cycles, 32 ns, short of the 35 ns strobe width
	sequence wrLow_s;
		(!writeStrobe_n)[*8];
	endsequence
	latch_excl_a: assert property (!(cmdLatch && addrLatch)) else $error("latch overlap");
	strobe_excl_a: assert property (!writeStrobe_n |-> read_strobe_n) else $error("strobe overlap");
	wr_select_a: assert property (!writeStrobe_n |-> !chipSel_n && ioOe)
		else $error("write strobe unselected");
	rd_pattern_a: assert property (!read_strobe_n |-> !cmdLatch && !addrLatch && !chipSel_n)
		else $error("read strobe pattern");
	rd_float_a: assert property (!read_strobe_n |-> !ioOe) else $error("port driven in read");
	wr_width_a: assert property ($fell(writeStrobe_n) |-> wrLow_s) else $error("short strobe");
	wr_hold_a: assert property (!writeStrobe_n && !$fell(writeStrobe_n)
		|-> $stable(ioOut) && $stable(cmdLatch) && $stable(addrLatch)) else $error("byte moved");
	rdata_idle_a: assert property (!$past(regRead) |-> regRdData == 32'h0) else $error("stray data");
endmodule : nfc_host_assertions
bind nfc_host nfc_host_assertions i_nfc_host_assertions (.sys_clk(sys_clk), .reset(reset),
	.regRead(regRead), .regRdData(regRdData), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
	.chipSel_n(chipSel_n), .writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n),
	.ioOut(ioOut), .ioOe(ioOe));
`default_nettype wire

// ---- bench/nfc_nand_model.sv ----
`default_nettype none
module nfc_nand_model import nfc_pkg::*; #(
	parameter int T_R     = 20_000,
	parameter int T_PROG  = 250_000,
	parameter int T_ERASE = 2_000_000
) (
	input  wire logic       cmdLatch,
	input  wire logic       addrLatch,
	input  wire logic       chipSel_n,
	input  wire logic       writeStrobe_n,
	input  wire logic       read_strobe_n,
	input  wire logic       writeProt_n,
	input  wire logic [7:0] io,
	output logic      [7:0] dOut,
	output logic            ready_busy_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// 16 page address bits; the pointer parks on the very last byte
	localparam int LAST_ADDR = 65536 * PAGE_BYTES - 1;
	logic [7:0] mem [int];
	logic [7:0] pb [int];
	logic [7:0] cmd = 8'h00;
	logic [7:0] last = 8'h00;
	int col = 0;
	int base = 0;
	int pg = 0;
	int na = 0;
	int selBusy = 0;
	logic prog = 1'b0;
	logic stat = 1'b0;
	logic fail = 1'b0;
	initial ready_busy_n = 1'b1;
	initial dOut = 8'hFF;
	// open drain busy; forked so status and reset still get through
	task automatic busy(input int t);
		ready_busy_n = 1'b0;
		#(t);
		ready_busy_n = 1'b1;
	endtask : busy
	// command, address and data on the rising write strobe
	always @(posedge writeStrobe_n) begin
		if (!chipSel_n && cmdLatch && (ready_busy_n || io inside {CMD_STATUS, CMD_RESET})) begin
			stat = (io == CMD_STATUS);
			if (io != CMD_PROG_EXEC) prog = 1'b0;
			cmd = io;
			na = (io == CMD_ERASE_SETUP);
			case (io)
				CMD_READ_A, CMD_READ_B: base = io * 256;
				CMD_READ_SPARE: base = MAIN_BYTES;
				CMD_SERIAL_IN: begin prog = 1'b1; pb.delete(); end
				CMD_RESET: fail = 1'b0;
				CMD_PROG_EXEC: if (prog) begin
					fail = !writeProt_n;
					foreach (pb[i]) if (writeProt_n) mem[pg * PAGE_BYTES + i] = pb[i];
					pb.delete();
					fork busy(T_PROG); join_none
				end
				CMD_ERASE_CONF: begin
					fail = !writeProt_n;
					for (int i = 0; i < BLOCK_PAGES * PAGE_BYTES; i++)
						if (writeProt_n) mem.delete(pg / BLOCK_PAGES * BLOCK_PAGES * PAGE_BYTES + i);
					fork busy(T_ERASE); join_none
				end
				default: ;
			endcase
		end else if (!chipSel_n && addrLatch) begin
			if (na == 0) col = base + io;
			else if (na == 1) pg = {pg[15:8], io};
			else pg = {io, pg[7:0]};
			na++;
			if (na == 3 && cmd inside {CMD_READ_A, CMD_READ_B, CMD_READ_SPARE}) fork busy(T_R); join_none
		end else if (!chipSel_n && prog) begin
			pb[col] = io;
			col++;
		end
	end
	// byte out on the falling read strobe, pointer moves on
	always @(negedge read_strobe_n) if (!chipSel_n) begin
		last = mem.exists(pg * PAGE_BYTES + col) ? mem[pg * PAGE_BYTES + col] : 8'hFF;
		if (stat) last = {writeProt_n, ready_busy_n, 5'h00, fail};
		else if (pg * PAGE_BYTES + col < LAST_ADDR) col++;
		dOut = last;
	end
	// a released port shows the inverse, never a stale byte
	always @(posedge read_strobe_n or posedge chipSel_n) dOut = ~last;
	// select must not rise while busy; the part would ignore it anyway
	always @(posedge chipSel_n) if (!ready_busy_n) selBusy++;
endmodule : nfc_nand_model
`default_nettype wire

// ---- bench/tb_nfc_host.sv ----
`default_nettype none
module tb_nfc_host import nfc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] regRdData, d;
	logic cmdLatch, addrLatch, chipSel_n, writeStrobe_n, read_strobe_n, writeProt_n, ioOe;
	logic ready_busy_n;
	logic [7:0] ioOut, ioIn, dOut;
	logic [31:0] wp = 32'h100;
	int fails = 0;
	int checked = 0;
	typedef struct {logic [15:0] pg; logic [1:0] rg; logic [7:0] col; logic [7:0] val;} nfc_row_t;
	nfc_row_t rows [4] = '{'{16'h0000, 2'h0, 8'h00, 8'h5A}, '{16'hFFFF, 2'h1, 8'hFE, 8'hC3},
		'{16'h0123, 2'h2, 8'h0E, 8'h96}, '{16'h0020, 2'h0, 8'h80, 8'h01}};
	// the host wins the port while it drives, otherwise the part's level
	assign ioIn = ioOe ? ioOut : dOut;
	always #2 sys_clk = ~sys_clk;
	nfc_host #(.BUSY_TIMEOUT(2000)) i_nfc_host (.sys_clk(sys_clk), .reset(reset),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .cmdLatch(cmdLatch), .addrLatch(addrLatch), .chipSel_n(chipSel_n),
		.writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n), .writeProt_n(writeProt_n),
		.ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn), .ready_busy_n(ready_busy_n));
	nfc_nand_model #(.T_R(400), .T_PROG(1200), .T_ERASE(2000)) i_nfc_nand_model (
		.cmdLatch(cmdLatch), .addrLatch(addrLatch), .chipSel_n(chipSel_n),
		.writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n), .writeProt_n(writeProt_n),
		.io(ioOut), .dOut(dOut), .ready_busy_n(ready_busy_n));
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		regAddr <= a;
		regWrData <= v;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 d = regRdData;
		@(posedge sys_clk);
	endtask : rd
	// bounded poll; a hang or a ready timeout fails the status compare
	task automatic poll();
		d = 32'h1;
		for (int n = 0; n < 3000 && d[0] !== 1'b0; n++) rd(REG_STATUS);
		chk("status", 32'h2, d);
	endtask : poll
	task automatic op(input logic [31:0] c);
		wr(REG_CTRL, wp | c);
		poll();
	endtask : op
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic getByte(input logic [7:0] e);
		op(NFC_OP_RBYTE);
		rd(REG_RDATA);
		chk("read byte", {24'h0, e}, d);
	endtask : getByte
	task automatic conclude();
		$display("compares %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		chk("protect", 32'h0, {31'h0, writeProt_n});
		chk("select", 32'h1, {31'h0, chipSel_n});
		i_nfc_nand_model.mem[16'hFFFF * PAGE_BYTES + PAGE_BYTES - 1] = 8'h3C;
		wr(REG_ADDR, {7'h0, 16'hFFFF, 1'b0, 8'h0F});
		op({2'h2, NFC_OP_READ});
		getByte(8'h3C);
		getByte(8'h3C);
		$display("end of array done");
		foreach (rows[i]) begin
			i_nfc_nand_model.mem[rows[i].pg * PAGE_BYTES + rows[i].rg * 256 + rows[i].col] =
				rows[i].val;
			i_nfc_nand_model.mem[rows[i].pg * PAGE_BYTES + rows[i].rg * 256 + rows[i].col + 1] =
				~rows[i].val;
			wr(REG_ADDR, {7'h0, rows[i].pg, 1'b0, rows[i].col});
			op({rows[i].rg, NFC_OP_READ});
			getByte(rows[i].val);
			getByte(~rows[i].val);
		end
		$display("table reads done");
		wr(REG_ADDR, 32'h0000_0A03);
		op(NFC_OP_PROG);
		wr(REG_WDATA, 32'h0000_00A5);
		op(NFC_OP_WBYTE);
		op(NFC_OP_EXEC);
		op(NFC_OP_STATUS);
		getByte(8'hC0);
		op(NFC_OP_READ);
		getByte(8'hA5);
		$display("program done");
		op(NFC_OP_ERASE);
		wr(REG_CTRL, wp | NFC_OP_READ);
		wr(REG_CTRL, wp | NFC_OP_STATUS);
		poll();
		getByte(8'hFF);
		$display("erase done");
		wp = 32'h0;
		op(NFC_OP_PROG);
		op(NFC_OP_WBYTE);
		op(NFC_OP_EXEC);
		op(NFC_OP_STATUS);
		getByte(8'h41);
		wp = 32'h100;
		for (int k = 1; k <= 4; k++) begin
			wr(REG_WDATA, k);
			op(NFC_OP_PROG);
			op(NFC_OP_WBYTE);
			op(NFC_OP_EXEC);
		end
		op(NFC_OP_READ);
		getByte(8'h03);
		$display("program limit done");
		op(NFC_OP_RESET);
		op(NFC_OP_STATUS);
		getByte(8'hC0);
		op(32'h0);
		chk("select end", 32'h1, {31'h0, chipSel_n});
		chk("select in busy", 32'h0, i_nfc_nand_model.selBusy);
		$display("protect and end done");
		conclude();
	end
	// about five times what the whole sequence needs
	initial begin
		#100_000;
		fails++;
		conclude();
	end
endmodule : tb_nfc_host
`default_nettype wire
